// File: rtl/wprs_params.svh
`ifndef WPRS_PARAMS_SVH
`define WPRS_PARAMS_SVH
// register offsets (word index on the plain port)
`define WPRS_ADDR_CTRL      8'h00
`define WPRS_ADDR_MIN_MASK  8'h01
`define WPRS_ADDR_STATUS    8'h02
`define WPRS_ADDR_ON_FLAGS  8'h03
`define WPRS_ADDR_TRANS     8'h04
`define WPRS_ADDR_SEL       8'h05
`define WPRS_ADDR_TIME_ON   8'h06
`define WPRS_ADDR_TIME_OFF  8'h07
`define WPRS_ADDR_DEPS      8'h08
`define WPRS_ADDR_CLK_MAP   8'h09
`define WPRS_ADDR_TMR_REQ   8'h0a
`define WPRS_ADDR_TMR_CNT   8'h0b
// ctrl fields
`define WPRS_CTRL_DOZE      0
`define WPRS_CTRL_DEEP      1
`define WPRS_CTRL_DYN_LDO   2
// reset values
`define WPRS_MIN_MASK_RST   8'h00
`define WPRS_CTRL_RST       3'h0
// low-power clock, figures in Hz and clock rate in Hz
`define WPRS_LPO_HZ         32768
`define WPRS_CLK_HZ         25000000
// divider count: clk periods per lpo tick, rounded down
`define WPRS_LPO_DIV        (`WPRS_CLK_HZ / `WPRS_LPO_HZ)
`endif

// File: rtl/wprs_pkg.sv
package wprs_pkg;
  // chip power state
  typedef enum logic [2:0] {
    WPRS_OFF    = 3'b000,
    WPRS_ACTIVE = 3'b001,
    WPRS_DOZE   = 3'b010,
    WPRS_SAVE   = 3'b011,
    WPRS_DEEP   = 3'b100,
    WPRS_RESTORE= 3'b101
  } wprs_pstate_t;
  // per-resource condition
  typedef enum logic [1:0] {
    WPRS_R_OFF   = 2'b00,
    WPRS_R_ON    = 2'b01,
    WPRS_R_GO_ON = 2'b10,
    WPRS_R_GO_OFF= 2'b11
  } wprs_rstate_t;
endpackage

// File: rtl/wprs_sequencer.sv
`timescale 1ns/1ps
`include "wprs_params.svh"
// Contract
// RULE1 - core switching and both linear regulators come up when either enable goes active
// RULE2 - regulators go down only when both enables are inactive
// RULE3 - each enable releases its own section from reset independently
// RULE4 - linear regulators may follow baseband demand at run time
// RULE5 - request is core clock demand, minimum mask and active request timers
// RULE6 - each core clock request maps to the resources that make it
// RULE7 - each resource sits in exactly one of four states
// RULE8 - resource timer is zero when stable, non-zero in transition
// RULE9 - a change loads the timer with the turn-on or turn-off delay
// RULE10 - timers count down per low-power tick; zero completes the transition
// RULE11 - a zero delay switches the resource directly with no transition
// RULE12 - each tick first computes the required set through the dependency table
// RULE13 - each tick decrements timers; reaching zero clears transition and flips on flag
// RULE14 - start disable for enabled, unrequested resources with no powered dependents
// RULE15 - start enable for disabled, requested resources with all dependencies on
// RULE16 - doze stops pll and reference oscillator, low-power tick keeps running
// RULE17 - entering deep sleep saves core state into retention before core power-off
// RULE18 - deep sleep exits on timer, external interrupt or host resume, then restores
// RULE19 - power-down has all regulators off; only the enable inputs bring it back
// RULE20 - in shutdown all outputs tristate and most input receivers are off
// RULE21 - power-on from shutdown is a clean power-up with no retained state
// RULE22 - high wlan enable powers regulators and releases wlan; low holds it reset
// RULE23 - dependencies, delays and minimum mask are writable and sampled on the tick
module wprs_sequencer
  import wprs_pkg::*;
#(
  parameter int NRES    = 8,
  parameter int NCORE   = 4,
  parameter int TW      = 8,
  parameter int DIV     = `WPRS_LPO_DIV,
  parameter int PIN_W   = 8
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             clk_en_i,
  input  wire logic             bluetooth_power_enable_i,
  input  wire logic             wlan_power_enable_i,
  input  wire logic [NCORE-1:0] core_clk_req_i,
  input  wire logic             ext_irq_i,
  input  wire logic             host_resume_i,
  input  wire logic             save_done_i,
  input  wire logic             restore_done_i,
  input  wire logic [PIN_W-1:0] io_out_i,
  input  wire logic [PIN_W-1:0] io_oe_i,
  input  wire logic [PIN_W-1:0] io_pin_i,
  input  wire logic [7:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [31:0]      rdata_o,
  output logic                  core_switching_regulator_en_o,
  output logic                  core_linear_regulator_en_o,
  output logic                  low_noise_linear_regulator_en_o,
  output logic                  bt_reset_o,
  output logic                  wlan_reset_o,
  output logic                  pll_en_o,
  output logic                  ref_osc_en_o,
  output logic                  retention_save_o,
  output logic                  retention_restore_o,
  output logic                  core_power_en_o,
  output logic      [NRES-1:0]  resource_on_flag_o,
  output logic      [NRES-1:0]  resource_transition_flag_o,
  output logic      [PIN_W-1:0] io_out_o,
  output logic      [PIN_W-1:0] io_oe_o,
  output logic      [PIN_W-1:0] io_in_o
);

  localparam int SW = $clog2(NRES) > 0 ? $clog2(NRES) : 1;
  localparam int DW = $clog2(DIV + 1);

  ////////////////////////////////////////////////////////////////////////
  // all state in one struct
  typedef struct packed {
    logic [2:0]             ctrl;
    logic [NRES-1:0]        min_mask;
    logic [SW-1:0]          sel;
    logic [NRES-1:0][TW-1:0] time_on;
    logic [NRES-1:0][TW-1:0] time_off;
    logic [NRES-1:0][NRES-1:0] deps;
    logic [NCORE-1:0][NRES-1:0] clk_map;
    logic [NRES-1:0]        tmr_req;
    logic [15:0]            tmr_cnt;
    logic [NRES-1:0][TW-1:0] timer;
    logic [NRES-1:0]        on_flag;
    logic [NRES-1:0]        trans;
    logic [DW-1:0]          div;
    wprs_pstate_t           pstate;
    logic [31:0]            rdata;
  } wprs_state_t;

  wprs_state_t st;
  wprs_state_t next_st;

  logic            any_en;
  logic            tick;
  logic [NRES-1:0] clk_res;
  logic [NRES-1:0] req_raw;
  logic [NRES-1:0] required;
  logic [NRES-1:0] powered;
  logic [NRES-1:0] dependents_up;
  logic [NRES-1:0] deps_ok;
  logic            wake;

  // rail control is the or of both enables
  assign any_en = bluetooth_power_enable_i | wlan_power_enable_i; // [RULE1] [RULE2] [RULE22]
  assign tick   = (st.div == DW'(DIV - 1));

  ////////////////////////////////////////////////////////////////////////
  // request and dependency terms, one slice per resource
  always_comb begin
    clk_res = '0;
    for (int c = 0; c < NCORE; c++) begin
      if (core_clk_req_i[c]) begin
        clk_res = clk_res | st.clk_map[c]; // [RULE6]
      end
    end
  end

  assign req_raw = clk_res | st.min_mask | ((st.tmr_cnt != 16'h0000) ? st.tmr_req : '0); // [RULE5]
  assign powered = st.on_flag | st.trans;

  generate
    for (genvar r = 0; r < NRES; r++) begin : g_res
      // a resource is required if requested or needed by a requested one (one level only, not propagated over ticks)
      logic [NRES-1:0] need_by;
      logic [NRES-1:0] up_by;
      for (genvar k = 0; k < NRES; k++) begin : g_dep
        assign need_by[k] = req_raw[k] & st.deps[k][r];
        assign up_by[k]   = powered[k] & st.deps[k][r];
      end
      assign required[r]      = req_raw[r] | (|need_by);           // [RULE12]
      assign dependents_up[r] = |up_by;
      assign deps_ok[r]       = ((st.deps[r] & ~st.on_flag) == '0) &
                                ((st.deps[r] & st.trans) == '0);
    end
  endgenerate

  // deep-sleep wake sources; tick-timer expiry counts as a sequencer timer event
  assign wake = ext_irq_i | host_resume_i | (tick && st.tmr_cnt == 16'h0001); // [RULE18]

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = st;
    // lpo tick divider, kept running in doze for the sequencer alone
    next_st.div = tick ? '0 : DW'(st.div + 1'b1); // [RULE16]

    // register writes; delays, deps and mask only reach the walk on a tick
    if (wr_i) begin // [RULE23]
      case (addr_i)
        `WPRS_ADDR_CTRL:     next_st.ctrl = wdata_i[2:0];
        `WPRS_ADDR_MIN_MASK: next_st.min_mask = wdata_i[NRES-1:0];
        `WPRS_ADDR_SEL:      next_st.sel = wdata_i[SW-1:0];
        `WPRS_ADDR_TIME_ON:  next_st.time_on[st.sel] = wdata_i[TW-1:0];
        `WPRS_ADDR_TIME_OFF: next_st.time_off[st.sel] = wdata_i[TW-1:0];
        `WPRS_ADDR_DEPS:     next_st.deps[st.sel] = wdata_i[NRES-1:0];
        `WPRS_ADDR_CLK_MAP:  next_st.clk_map[st.sel[$clog2(NCORE)-1:0]] = wdata_i[NRES-1:0];
        `WPRS_ADDR_TMR_REQ:  next_st.tmr_req = wdata_i[NRES-1:0];
        `WPRS_ADDR_TMR_CNT:  next_st.tmr_cnt = wdata_i[15:0];
        default: ;
      endcase
    end

    // resource walk, once per low-power tick
    if (tick && st.pstate != WPRS_OFF) begin
      if (st.tmr_cnt != 16'h0000 && !(wr_i && addr_i == `WPRS_ADDR_TMR_CNT)) begin
        next_st.tmr_cnt = st.tmr_cnt - 16'h0001;
      end
      for (int r = 0; r < NRES; r++) begin
        if (st.timer[r] != '0) begin
          next_st.timer[r] = st.timer[r] - 1'b1; // [RULE10] [RULE13]
          if (st.timer[r] == TW'(1)) begin
            next_st.trans[r]   = 1'b0;            // [RULE13]
            next_st.on_flag[r] = ~st.on_flag[r];  // [RULE13] [RULE10]
          end
        end else if (st.on_flag[r] && !required[r] && !dependents_up[r]) begin // [RULE14]
          if (st.time_off[r] == '0) begin
            next_st.on_flag[r] = 1'b0;              // [RULE11]
          end else begin
            next_st.timer[r] = st.time_off[r];      // [RULE9]
            next_st.trans[r] = 1'b1;                // [RULE8]
          end
        end else if (!st.on_flag[r] && required[r] && deps_ok[r]) begin // [RULE15]
          if (st.time_on[r] == '0) begin
            next_st.on_flag[r] = 1'b1;              // [RULE11]
          end else begin
            next_st.timer[r] = st.time_on[r];       // [RULE9]
            next_st.trans[r] = 1'b1;                // [RULE8]
          end
        end
      end
    end

    // chip power state
    case (st.pstate)
      WPRS_OFF: begin
        if (any_en) begin
          next_st.pstate = WPRS_ACTIVE; // [RULE19]
        end
      end
      WPRS_ACTIVE: begin
        if (st.ctrl[`WPRS_CTRL_DEEP]) begin
          next_st.pstate = WPRS_SAVE;
        end else if (st.ctrl[`WPRS_CTRL_DOZE]) begin
          next_st.pstate = WPRS_DOZE;
        end
      end
      WPRS_DOZE: begin
        if (!st.ctrl[`WPRS_CTRL_DOZE] || wake) begin
          next_st.pstate = WPRS_ACTIVE;
          next_st.ctrl[`WPRS_CTRL_DOZE] = 1'b0;
        end
      end
      WPRS_SAVE: begin
        if (save_done_i) begin
          next_st.pstate = WPRS_DEEP; // [RULE17]
        end
      end
      WPRS_DEEP: begin
        if (wake) begin
          next_st.pstate = WPRS_RESTORE; // [RULE18]
        end
      end
      WPRS_RESTORE: begin
        if (restore_done_i) begin
          next_st.pstate = WPRS_ACTIVE;
          next_st.ctrl[`WPRS_CTRL_DEEP] = 1'b0;
        end
      end
      default: next_st.pstate = WPRS_OFF;
    endcase

    // both enables low drops everything but the lpo tick divider, which keeps counting; no other state kept
    if (!any_en) begin
      next_st = '0; // [RULE2] [RULE19] [RULE21]
      next_st.min_mask = `WPRS_MIN_MASK_RST;
      next_st.div = DW'(st.div == DW'(DIV - 1) ? 0 : st.div + 1'b1);
    end

    // read data valid only in the cycle after the strobe
    next_st.rdata = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        `WPRS_ADDR_CTRL:     next_st.rdata = {29'h0, st.ctrl};
        `WPRS_ADDR_MIN_MASK: next_st.rdata = 32'(st.min_mask);
        `WPRS_ADDR_STATUS:   next_st.rdata = {29'h0, st.pstate};
        `WPRS_ADDR_ON_FLAGS: next_st.rdata = 32'(st.on_flag);
        `WPRS_ADDR_TRANS:    next_st.rdata = 32'(st.trans);
        `WPRS_ADDR_SEL:      next_st.rdata = 32'(st.sel);
        `WPRS_ADDR_TIME_ON:  next_st.rdata = 32'(st.time_on[st.sel]);
        `WPRS_ADDR_TIME_OFF: next_st.rdata = 32'(st.time_off[st.sel]);
        `WPRS_ADDR_DEPS:     next_st.rdata = 32'(st.deps[st.sel]);
        `WPRS_ADDR_CLK_MAP:  next_st.rdata = 32'(st.clk_map[st.sel[$clog2(NCORE)-1:0]]);
        `WPRS_ADDR_TMR_REQ:  next_st.rdata = 32'(st.tmr_req);
        `WPRS_ADDR_TMR_CNT:  next_st.rdata = {16'h0, st.tmr_cnt};
        default:             next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; clock enable freezes everything, but sys_rst_i still clears it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st <= '0; // [RULE21]
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  logic live;
  logic dyn;
  assign live = (st.pstate != WPRS_OFF);
  assign dyn  = st.ctrl[`WPRS_CTRL_DYN_LDO];

  assign rdata_o                         = st.rdata;
  assign core_switching_regulator_en_o   = live;                                           // [RULE1] [RULE19]
  // with dynamic mode set, resource 0/1 steer the linear regulators
  assign core_linear_regulator_en_o      = live & (!dyn | st.on_flag[0]);                  // [RULE4]
  assign low_noise_linear_regulator_en_o = live & (!dyn | st.on_flag[1 % NRES]);           // [RULE4]
  assign bt_reset_o                      = !(live & bluetooth_power_enable_i);              // [RULE3]
  assign wlan_reset_o                    = !(live & wlan_power_enable_i);                   // [RULE3] [RULE22]
  assign pll_en_o                        = (st.pstate == WPRS_ACTIVE);                      // [RULE16]
  assign ref_osc_en_o                    = (st.pstate == WPRS_ACTIVE) |
                                           (st.pstate == WPRS_SAVE) |
                                           (st.pstate == WPRS_RESTORE);                     // [RULE16]
  assign retention_save_o                = (st.pstate == WPRS_SAVE);                        // [RULE17]
  assign retention_restore_o             = (st.pstate == WPRS_RESTORE);                     // [RULE18]
  assign core_power_en_o                 = live & (st.pstate != WPRS_DEEP);                 // [RULE17]
  assign resource_on_flag_o              = st.on_flag;                                      // [RULE7]
  assign resource_transition_flag_o      = st.trans;                                        // [RULE7]
  // shutdown: pads released and receivers gated
  assign io_out_o                        = live ? io_out_i : '0;                            // [RULE20]
  assign io_oe_o                         = live ? io_oe_i : '0;                             // [RULE20]
  assign io_in_o                         = live ? io_pin_i : '0;                            // [RULE20]

endmodule

// File: test/wprs_host_model.sv
`timescale 1ns/1ps
module wprs_host_model (
  input  wire logic clk_i,
  input  wire logic slow_i,
  input  wire logic bt_want_i,
  input  wire logic wl_want_i,
  output logic      bluetooth_power_enable_o,
  output logic      wlan_power_enable_o
);
  logic [1:0] wait_cnt = 2'h0;
  initial begin
    bluetooth_power_enable_o = 1'b0;
    wlan_power_enable_o = 1'b0;
  end
  // a slow host lets a request age three clocks before the pins move
  always @(posedge clk_i) begin
    if ({bt_want_i, wl_want_i} == {bluetooth_power_enable_o, wlan_power_enable_o}) begin
      wait_cnt <= 2'h0;
    end else if (!slow_i || wait_cnt == 2'h3) begin
      bluetooth_power_enable_o <= bt_want_i; // only the pins bring it back from power-down
      wlan_power_enable_o <= wl_want_i;
      wait_cnt <= 2'h0;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

// File: test/wprs_sequencer_props.sv
`timescale 1ns/1ps
module wprs_sequencer_props #(
  parameter int NRES  = 8,
  parameter int PIN_W = 8
) (
  input wire logic             clk_i,
  input wire logic             sys_rst_i,
  input wire logic             bluetooth_power_enable_i,
  input wire logic             wlan_power_enable_i,
  input wire logic             rd_i,
  input wire logic [31:0]      rdata_o,
  input wire logic             core_switching_regulator_en_o,
  input wire logic             core_linear_regulator_en_o,
  input wire logic             bt_reset_o,
  input wire logic             wlan_reset_o,
  input wire logic             retention_save_o,
  input wire logic             core_power_en_o,
  input wire logic [NRES-1:0]  resource_on_flag_o,
  input wire logic [NRES-1:0]  resource_transition_flag_o,
  input wire logic [PIN_W-1:0] io_out_o,
  input wire logic [PIN_W-1:0] io_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire             live = bluetooth_power_enable_i || wlan_power_enable_i;
  logic [NRES-1:0] tr_q;
  logic [NRES-1:0] on_q;
  logic [NRES-1:0] done;
  // last flags, to see which transitions just ended
  always_ff @(posedge clk_i) begin
    tr_q <= resource_transition_flag_o;
    on_q <= resource_on_flag_o;
  end
  assign done = tr_q & ~resource_transition_flag_o;
  ////////////////////////////////////////////////////////////////////////////
  a_regs_come_up: assert property ($rose(live) ##1 live [*2] |-> core_switching_regulator_en_o)
    else $error("switching regulator still off after an enable rose");
  a_regs_go_off: assert property (!live [*3] |-> !core_switching_regulator_en_o && !core_linear_regulator_en_o)
    else $error("regulator on with both enables low");
  a_bt_held: assert property (!bluetooth_power_enable_i [*2] |-> bt_reset_o)
    else $error("bluetooth section out of reset without its enable");
  a_wl_held: assert property (!wlan_power_enable_i [*2] |-> wlan_reset_o)
    else $error("wlan section out of reset without its enable");
  a_wl_release: assert property ($rose(wlan_power_enable_i) ##1 wlan_power_enable_i [*2] |-> !wlan_reset_o)
    else $error("wlan section kept in reset");
  a_done_flips: assert property (live && $past(live) && (|done) |-> ((on_q ^ resource_on_flag_o) & done) == done)
    else $error("finished transition did not invert the on flag");
  a_save_first: assert property ($fell(core_power_en_o) && live |-> $past(retention_save_o))
    else $error("core powered off without a retention save");
  a_io_quiet: assert property (!live [*2] |-> io_oe_o == '0 && io_out_o == '0)
    else $error("pads driven while shut down");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside the answer cycle");
  c_power_up: cover property ($rose(core_switching_regulator_en_o));
  c_deep_sleep: cover property ($fell(core_power_en_o) && live);
  c_res_on: cover property ($rose(|resource_on_flag_o));
endmodule
bind wprs_sequencer wprs_sequencer_props #(.NRES(NRES), .PIN_W(PIN_W)) i_props (
  .clk_i, .sys_rst_i, .bluetooth_power_enable_i, .wlan_power_enable_i, .rd_i, .rdata_o,
  .core_switching_regulator_en_o, .core_linear_regulator_en_o, .bt_reset_o, .wlan_reset_o,
  .retention_save_o, .core_power_en_o, .resource_on_flag_o, .resource_transition_flag_o, .io_out_o, .io_oe_o
);

// File: test/wprs_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "wprs_params.svh"
module wprs_sequencer_tb_top import wprs_pkg::*; ;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1, slow = 1'b0, bt_want = 1'b0, wl_want = 1'b0;
  logic        ext_irq_i = 1'b0, host_resume_i = 1'b0, save_done_i = 1'b0, restore_done_i = 1'b0;
  logic        wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0, bluetooth_power_enable_i, wlan_power_enable_i;
  logic [3:0]  core_clk_req_i = 4'h0;
  logic [7:0]  io_out_i = 8'h00, io_oe_i = 8'h00, io_pin_i = 8'h00, addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic        core_switching_regulator_en_o, core_linear_regulator_en_o, bt_reset_o, wlan_reset_o;
  logic        pll_en_o, ref_osc_en_o, retention_save_o, retention_restore_o, core_power_en_o;
  logic [7:0]  resource_on_flag_o, resource_transition_flag_o, io_out_o, io_oe_o, io_in_o;
  logic        low_noise_linear_regulator_en_o;
  logic [31:0] exp_q[$], msk_q[$];
  int          error_cnt = 0, samples_checked = 0;
  always #20 clk_i = ~clk_i;
  // tick every 4 clocks keeps the delay scenarios short
  wprs_sequencer #(.DIV(4)) i_dut (.clk_i, .sys_rst_i, .clk_en_i, .bluetooth_power_enable_i, .wlan_power_enable_i,
    .core_clk_req_i, .ext_irq_i, .host_resume_i, .save_done_i, .restore_done_i, .io_out_i, .io_oe_i, .io_pin_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .core_switching_regulator_en_o, .core_linear_regulator_en_o,
    .low_noise_linear_regulator_en_o, .bt_reset_o, .wlan_reset_o, .pll_en_o, .ref_osc_en_o, .retention_save_o,
    .retention_restore_o, .core_power_en_o, .resource_on_flag_o, .resource_transition_flag_o, .io_out_o, .io_oe_o,
    .io_in_o);
  wprs_host_model i_host (.clk_i, .slow_i(slow), .bt_want_i(bt_want), .wl_want_i(wl_want),
    .bluetooth_power_enable_o(bluetooth_power_enable_i), .wlan_power_enable_o(wlan_power_enable_i));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // the read answer is judged by the monitor below, one cycle on
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic host(input logic b, input logic w);
    bt_want <= b;
    wl_want <= w;
    cyc(8);
  endtask
  task automatic settle(input int k, input logic tgt, output int n, output logic tr);
    tr = 1'b0;
    for (n = 0; n < 400 && resource_on_flag_o[k] !== tgt; n++) begin
      cyc(1);
      tr |= resource_transition_flag_o[k];
    end
    if (n == 400) begin
      chk("settle timeout", 32'h0, 32'h1);
      tally_and_finish();
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // read answers stand only in the cycle after the strobe
  always @(posedge clk_i) rd_d <= rd_i;
  always @(negedge clk_i) begin
    if (rd_d) begin
      if (exp_q.size() == 0) chk("unexpected read", 32'h0, 32'h1);
      else chk("read data", exp_q.pop_front(), rdata_o & msk_q.pop_front());
    end
  end
  initial begin
    int          n;
    logic        t;
    int unsigned seed;
    seed = $urandom(34);
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    cyc(2);
    chb("switching reg", 1'b0, core_switching_regulator_en_o);
    rd(`WPRS_ADDR_MIN_MASK, 32'h0, 32'hff);
    host(1'b1, 1'b0);
    chb("switching reg", 1'b1, core_switching_regulator_en_o);
    chb("bt reset", 1'b0, bt_reset_o);
    chb("wlan reset", 1'b1, wlan_reset_o);
    rd(`WPRS_ADDR_STATUS, {29'h0, WPRS_ACTIVE}, 32'h7);
    slow <= 1'b1;
    host(1'b0, 1'b1);
    chb("linear reg", 1'b1, core_linear_regulator_en_o);
    chb("wlan reset", 1'b0, wlan_reset_o);
    chb("bt reset", 1'b1, bt_reset_o);
    slow <= 1'b0;
    // resource 3 with a six-tick turn-on
    wr(`WPRS_ADDR_SEL, 32'h3);
    wr(`WPRS_ADDR_TIME_ON, 32'h6);
    wr(`WPRS_ADDR_MIN_MASK, 32'h08);
    settle(3, 1'b1, n, t);
    chb("turn-on wait", 1'b1, n >= 20 && n <= 40);
    chb("turn-on pending", 1'b1, t);
    rd(`WPRS_ADDR_ON_FLAGS, 32'h08, 32'h08);
    // resource 4 depends on 3 and switches with no delay
    wr(`WPRS_ADDR_SEL, 32'h4);
    wr(`WPRS_ADDR_DEPS, 32'h08);
    wr(`WPRS_ADDR_MIN_MASK, 32'h10);
    settle(4, 1'b1, n, t);
    chb("dependency on", 1'b1, resource_on_flag_o[3]);
    chb("direct on", 1'b0, t);
    wr(`WPRS_ADDR_MIN_MASK, 32'h0);
    settle(3, 1'b0, n, t);
    chb("dependent off first", 1'b0, resource_on_flag_o[4]);
    // core 2 clock request maps to resource 5
    wr(`WPRS_ADDR_SEL, 32'h2);
    wr(`WPRS_ADDR_CLK_MAP, 32'h20);
    @(posedge clk_i);
    core_clk_req_i <= 4'($urandom) | 4'h4;
    settle(5, 1'b1, n, t);
    @(posedge clk_i);
    core_clk_req_i <= 4'h0;
    settle(5, 1'b0, n, t);
    wr(`WPRS_ADDR_TMR_REQ, 32'h40);
    wr(`WPRS_ADDR_TMR_CNT, 32'h3);
    settle(6, 1'b1, n, t);
    settle(6, 1'b0, n, t);
    // doze, woken by an external interrupt
    wr(`WPRS_ADDR_CTRL, 32'h1);
    cyc(12);
    chb("pll in doze", 1'b0, pll_en_o);
    chb("osc in doze", 1'b0, ref_osc_en_o);
    @(posedge clk_i);
    ext_irq_i <= 1'b1;
    cyc(3);
    chb("pll after wake", 1'b1, pll_en_o);
    wr(`WPRS_ADDR_CTRL, 32'h0);
    ext_irq_i <= 1'b0;
    // deep sleep, left by a host resume
    wr(`WPRS_ADDR_CTRL, 32'h2);
    cyc(12);
    chb("saving", 1'b1, retention_save_o);
    chb("core kept during save", 1'b1, core_power_en_o);
    @(posedge clk_i);
    save_done_i <= 1'b1;
    cyc(3);
    chb("core off", 1'b0, core_power_en_o);
    save_done_i <= 1'b0;
    wr(`WPRS_ADDR_CTRL, 32'h0);
    host_resume_i <= 1'b1;
    cyc(3);
    chb("restoring", 1'b1, retention_restore_o);
    @(posedge clk_i);
    host_resume_i <= 1'b0;
    restore_done_i <= 1'b1;
    cyc(3);
    chb("core back", 1'b1, core_power_en_o);
    @(posedge clk_i);
    restore_done_i <= 1'b0;
    // dynamic mode: linear regulators follow resources 0 and 1
    chb("low-noise static", 1'b1, low_noise_linear_regulator_en_o);
    wr(`WPRS_ADDR_CTRL, 32'h4);
    cyc(2);
    chb("linear dyn off", 1'b0, core_linear_regulator_en_o);
    chb("low-noise dyn off", 1'b0, low_noise_linear_regulator_en_o);
    wr(`WPRS_ADDR_MIN_MASK, 32'h02);
    settle(1, 1'b1, n, t);
    chb("low-noise dyn on", 1'b1, low_noise_linear_regulator_en_o);
    wr(`WPRS_ADDR_MIN_MASK, 32'h0);
    wr(`WPRS_ADDR_CTRL, 32'h0);
    @(posedge clk_i);
    io_out_i <= 8'($urandom);
    io_oe_i <= 8'($urandom);
    io_pin_i <= 8'($urandom);
    cyc(2);
    chk("pad drive", {24'h0, io_out_i}, {24'h0, io_out_o});
    chk("pad input", {24'h0, io_pin_i}, {24'h0, io_in_o});
    host(1'b0, 1'b0);
    chk("pad enable", 32'h0, {24'h0, io_oe_o});
    chk("pad input off", 32'h0, {24'h0, io_in_o});
    chb("low-noise off", 1'b0, low_noise_linear_regulator_en_o);
    chb("switching reg", 1'b0, core_switching_regulator_en_o);
    host(1'b1, 1'b0);
    rd(`WPRS_ADDR_TMR_REQ, 32'h0, 32'hff);
    rd(`WPRS_ADDR_SEL, 32'h0, 32'hff);
    rd(8'h3f, 32'h0, 32'hffffffff);
    cyc(3);
    tally_and_finish();
  end
endmodule
